// File: cpuex_pkg.sv
// Shared constants, types and state layout of the exception and reset controller
package cpuex_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS      = 100;   // 10 MHz core clock
  localparam int unsigned RST_READ_PERIOD_NS = 1600;  // Spacing of reads while held in reset
  localparam int unsigned RST_READ_CYC       =
    (RST_READ_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // Rounded up to cycles
  localparam int unsigned RCNT_W             = 8;     // Width of the read spacing counter
  localparam logic [RCNT_W-1:0] RCNT_RELOAD  = RCNT_W'(RST_READ_CYC - 1);

  // Widths
  localparam int unsigned DATA_W   = 32;  // Register and address width
  localparam int unsigned ADDR_W   = 4;   // Register port address width
  localparam int unsigned IRQ_N    = 32;  // Number of interrupt request lines
  localparam int unsigned EVT_W    = 3;   // Number of sticky event bits
  localparam int unsigned CAUSE_W  = 2;   // Exception cause code width
  localparam int unsigned OP_W     = 3;   // Issued instruction class width

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h0;  // Global enable and saved enable
  localparam logic [ADDR_W-1:0] REG_ENABLE   = 4'h1;  // Per-line interrupt enable mask
  localparam logic [ADDR_W-1:0] REG_PENDING  = 4'h2;  // Lines asserted and enabled, read only
  localparam logic [ADDR_W-1:0] REG_EVT      = 4'h3;  // Sticky events, write one to clear
  localparam logic [ADDR_W-1:0] REG_EVT_MASK = 4'h4;  // Event interrupt mask
  localparam logic [ADDR_W-1:0] REG_VECTOR   = 4'h5;  // Vector dispatch result, read only
  localparam logic [ADDR_W-1:0] REG_CAUSE    = 4'h6;  // Last exception cause, read only
  localparam logic [ADDR_W-1:0] REG_CONFIG   = 4'h7;  // Built-in hardware options, read only

  // Status register fields
  localparam int unsigned STAT_GIE_BIT   = 0;  // global_interrupt_enable
  localparam int unsigned STAT_SAVED_BIT = 1;  // Copy of the enable taken on entry

  // Config register fields
  localparam int unsigned CFG_MUL_BIT = 0;  // Multiply hardware present
  localparam int unsigned CFG_DIV_BIT = 1;  // Divide hardware present

  // Event bits
  localparam int unsigned EVT_TRAP = 0;  // Unimplemented instruction trapped
  localparam int unsigned EVT_IRQ  = 1;  // Hardware interrupt taken
  localparam int unsigned EVT_RST  = 2;  // Local reset entered

  // Exception cause codes
  localparam logic [CAUSE_W-1:0] CAUSE_NONE  = 2'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_IRQ   = 2'h1;
  localparam logic [CAUSE_W-1:0] CAUSE_UNIMP = 2'h2;

  // Issued instruction classes
  localparam logic [OP_W-1:0] OP_OTHER  = 3'h0;
  localparam logic [OP_W-1:0] OP_MUL    = 3'h1;  // Any of the multiply forms
  localparam logic [OP_W-1:0] OP_MULI   = 3'h2;
  localparam logic [OP_W-1:0] OP_MULXSS = 3'h3;
  localparam logic [OP_W-1:0] OP_MULXSU = 3'h4;
  localparam logic [OP_W-1:0] OP_MULXUU = 3'h5;
  localparam logic [OP_W-1:0] OP_DIV    = 3'h6;  // Any of the divide forms
  localparam logic [OP_W-1:0] OP_DIVU   = 3'h7;

  // Vector dispatch answer when nothing is to be dispatched
  localparam logic [DATA_W-1:0] VEC_NONE = 32'hFFFFFFFF;

  // Local reset sequencer states
  typedef enum logic [1:0] {
    RST_RUN,    // Executing normally
    RST_DRAIN,  // Finishing instructions already in the pipeline
    RST_HELD    // Held in reset
  } cpuex_rst_st_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cpuex_reg_req_t;

  // Exception redirect towards the fetch unit
  typedef struct packed {
    logic               take;
    logic [CAUSE_W-1:0] cause;
    logic [DATA_W-1:0]  addr;
  } cpuex_exc_t;

  // Whole controller state
  typedef struct packed {
    cpuex_rst_st_t      rst_st;
    logic [RCNT_W-1:0]  rcnt;
    logic               gie;
    logic               saved_gie;
    logic [IRQ_N-1:0]   ienable;
    logic [EVT_W-1:0]   evt;
    logic [EVT_W-1:0]   evt_mask;
    cpuex_exc_t         exc;
    logic [DATA_W-1:0]  rdata;
    logic [DATA_W-1:0]  ci_result;
    logic               ci_done;
    logic               rst_ack;
    logic               rst_rd_req;
    logic               in_reset;
  } cpuex_state_t;

  localparam cpuex_state_t STATE_RESET = '{rst_st: RST_RUN, default: '0};

endpackage

// File: cpuex_vec_enc.sv
// Lowest-set-bit encoder behind the vector dispatch instruction
`timescale 1ns/1ps

module cpuex_vec_enc (
  input  wire logic [cpuex_pkg::IRQ_N-1:0]  pending,
  input  wire logic                         saved_gie,
  output logic      [cpuex_pkg::DATA_W-1:0] result
);

  logic [4:0] idx;  // Index of the lowest asserted line
  logic       any;  // At least one line pending

  // Scan from the top so the lowest set bit is kept last
  always_comb begin
    idx = 5'h0;
    any = 1'b0;
    for (int i = cpuex_pkg::IRQ_N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        idx = 5'(i);
        any = 1'b1;
      end
    end
  end

  // Negative when idle or when the saved enable was off, else eight times the index
  always_comb begin
    if (!any || !saved_gie) begin
      result = cpuex_pkg::VEC_NONE;
    end else begin
      result = {24'h0, idx, 3'h0};
    end
  end

endmodule

// File: cpuex_ctrl.sv
// Exception, interrupt and local reset controller of the processor core
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module cpuex_ctrl #(
  parameter logic [cpuex_pkg::DATA_W-1:0] EXC_ADDR   = 32'h00000020,  // Common exception address
  parameter logic [cpuex_pkg::DATA_W-1:0] RESET_ADDR = 32'h00000000,  // Address read while held
  parameter logic                         HAS_MUL    = 1'b0,          // Multiply hardware built in
  parameter logic                         HAS_DIV    = 1'b0           // Divide hardware built in
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic [cpuex_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [cpuex_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [cpuex_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic [cpuex_pkg::IRQ_N-1:0]   irq_in,
  input  wire logic                          issue_valid,
  input  wire logic [cpuex_pkg::OP_W-1:0]    issue_op,
  output logic                               issue_stall,
  input  wire logic                          pipe_empty,
  input  wire logic                          exc_return,
  output logic                               exc_take,
  output logic      [cpuex_pkg::CAUSE_W-1:0] exc_cause,
  output logic      [cpuex_pkg::DATA_W-1:0]  exc_addr,
  input  wire logic                          ci_vec_req,
  output logic      [cpuex_pkg::DATA_W-1:0]  ci_vec_result,
  output logic                               ci_vec_done,
  input  wire logic                          local_reset_req,
  output logic                               local_reset_ack,
  output logic                               core_in_reset,
  input  wire logic                          dbg_active,
  output logic                               rst_rd_req,
  output logic      [cpuex_pkg::DATA_W-1:0]  rst_rd_addr,
  output logic                               irq_out
);

  // State registers and their next values
  cpuex_pkg::cpuex_state_t   st_q;        // Registered state
  cpuex_pkg::cpuex_state_t   st_d;        // Next state
  cpuex_pkg::cpuex_reg_req_t req;         // Bundled register port request

  // Decode helpers
  logic [cpuex_pkg::IRQ_N-1:0]  pending;      // Lines asserted and enabled
  logic                         irq_qual;     // Hardware interrupt qualified
  logic                         is_mul;       // Issued op is a multiply form
  logic                         is_div;       // Issued op is a divide form
  logic                         unimp;        // Issued op lacks hardware
  logic                         boundary;     // Instruction boundary with issue allowed
  logic [cpuex_pkg::DATA_W-1:0] vec_result;   // Vector dispatch answer
  logic [cpuex_pkg::DATA_W-1:0] rd_mux;       // Read data before registering
  logic [cpuex_pkg::EVT_W-1:0]  evt_set;      // Events raised this cycle
  logic [cpuex_pkg::EVT_W-1:0]  evt_clr;      // Events cleared by software
  logic                         wr_status;    // Status register written
  logic                         wr_enable;    // Enable mask written

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Priority-free pending word: any enabled line counts alike
  assign pending  = irq_in & st_q.ienable;
  assign irq_qual = st_q.gie && (|pending);

  // Classify the issued instruction
  always_comb begin
    is_mul = 1'b0;
    is_div = 1'b0;
    case (issue_op)
      cpuex_pkg::OP_MUL,
      cpuex_pkg::OP_MULI,
      cpuex_pkg::OP_MULXSS,
      cpuex_pkg::OP_MULXSU,
      cpuex_pkg::OP_MULXUU: begin
        is_mul = 1'b1;
      end
      cpuex_pkg::OP_DIV,
      cpuex_pkg::OP_DIVU: begin
        is_div = 1'b1;
      end
      default: begin
        is_mul = 1'b0;
        is_div = 1'b0;
      end
    endcase
  end

  // Missing arithmetic hardware turns the op into a trap
  assign unimp = (is_mul && !HAS_MUL) || (is_div && !HAS_DIV);

  // Issue is held off while draining or held in local reset
  assign issue_stall = (st_q.rst_st != cpuex_pkg::RST_RUN);
  assign boundary    = issue_valid && !issue_stall;

  // Vector dispatch encoder works on the enable saved at entry
  cpuex_vec_enc u_vec_enc (
    .pending   (pending),
    .saved_gie (st_q.saved_gie),
    .result    (vec_result)
  );

  // Software writes decoded from the register port
  assign wr_status = req.wr && (req.addr == cpuex_pkg::REG_STATUS);
  assign wr_enable = req.wr && (req.addr == cpuex_pkg::REG_ENABLE);

  // Write one to clear for the sticky event bits
  always_comb begin
    evt_clr = '0;
    if (req.wr && (req.addr == cpuex_pkg::REG_EVT)) begin
      evt_clr = req.wdata[cpuex_pkg::EVT_W-1:0];
    end
  end

  // Read multiplexer, zero for unmapped offsets
  always_comb begin
    rd_mux = '0;
    case (req.addr)
      cpuex_pkg::REG_STATUS: begin
        rd_mux[cpuex_pkg::STAT_GIE_BIT]   = st_q.gie;
        rd_mux[cpuex_pkg::STAT_SAVED_BIT] = st_q.saved_gie;
      end
      cpuex_pkg::REG_ENABLE: begin
        rd_mux = st_q.ienable;
      end
      cpuex_pkg::REG_PENDING: begin
        rd_mux = pending;
      end
      cpuex_pkg::REG_EVT: begin
        rd_mux[cpuex_pkg::EVT_W-1:0] = st_q.evt;
      end
      cpuex_pkg::REG_EVT_MASK: begin
        rd_mux[cpuex_pkg::EVT_W-1:0] = st_q.evt_mask;
      end
      cpuex_pkg::REG_VECTOR: begin
        rd_mux = vec_result;
      end
      cpuex_pkg::REG_CAUSE: begin
        rd_mux[cpuex_pkg::CAUSE_W-1:0] = st_q.exc.cause;
      end
      cpuex_pkg::REG_CONFIG: begin
        rd_mux[cpuex_pkg::CFG_MUL_BIT] = HAS_MUL;
        rd_mux[cpuex_pkg::CFG_DIV_BIT] = HAS_DIV;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Next-state logic for the whole controller
  always_comb begin
    st_d = st_q;

    // Single-cycle outputs fall back to idle
    st_d.exc.take   = 1'b0;
    st_d.rst_ack    = 1'b0;
    st_d.rst_rd_req = 1'b0;
    st_d.ci_done    = 1'b0;
    evt_set         = '0;

    // Read data stand only in the cycle after the strobe
    st_d.rdata = req.rd ? rd_mux : '0;

    // Register writes from software
    if (wr_status) begin
      st_d.gie       = req.wdata[cpuex_pkg::STAT_GIE_BIT];
      st_d.saved_gie = req.wdata[cpuex_pkg::STAT_SAVED_BIT];
    end
    if (wr_enable) begin
      st_d.ienable = req.wdata;
    end
    if (req.wr && (req.addr == cpuex_pkg::REG_EVT_MASK)) begin
      st_d.evt_mask = req.wdata[cpuex_pkg::EVT_W-1:0];
    end

    // Exception return restores the enable saved on entry
    if (exc_return) begin
      st_d.gie = st_q.saved_gie;
    end

    // Vector dispatch instruction answers one cycle after its request
    if (ci_vec_req) begin
      st_d.ci_result = vec_result;
      st_d.ci_done   = 1'b1;
    end

    // Exception entry at an instruction boundary; interrupts win over the trap
    if (boundary && irq_qual) begin
      st_d.exc.take    = 1'b1;
      st_d.exc.cause   = cpuex_pkg::CAUSE_IRQ;
      st_d.exc.addr    = EXC_ADDR;
      st_d.saved_gie   = st_q.gie;
      st_d.gie         = 1'b0;
      evt_set[cpuex_pkg::EVT_IRQ] = 1'b1;
    end else if (boundary && unimp) begin
      st_d.exc.take    = 1'b1;
      st_d.exc.cause   = cpuex_pkg::CAUSE_UNIMP;
      st_d.exc.addr    = EXC_ADDR;
      st_d.saved_gie   = st_q.gie;
      st_d.gie         = 1'b0;
      evt_set[cpuex_pkg::EVT_TRAP] = 1'b1;
    end

    // Local reset sequencer
    case (st_q.rst_st)
      cpuex_pkg::RST_RUN: begin
        // Request is a level, so after debug release it is judged anew
        if (local_reset_req && !dbg_active) begin
          st_d.rst_st = cpuex_pkg::RST_DRAIN;
        end
      end
      cpuex_pkg::RST_DRAIN: begin
        // Wait for instructions already issued to retire
        if (pipe_empty) begin
          st_d.rst_st     = cpuex_pkg::RST_HELD;
          st_d.in_reset   = 1'b1;
          st_d.rst_ack    = 1'b1;
          st_d.rst_rd_req = 1'b1;
          st_d.rcnt       = cpuex_pkg::RCNT_RELOAD;
          // Only core state is cleared; the rest of the system runs on
          st_d.gie        = 1'b0;
          st_d.saved_gie  = 1'b0;
          st_d.ienable    = '0;
          st_d.exc.cause  = cpuex_pkg::CAUSE_NONE;
          evt_set[cpuex_pkg::EVT_RST] = 1'b1;
        end
      end
      cpuex_pkg::RST_HELD: begin
        if (!local_reset_req) begin
          // Request released: leave reset and fetch again
          st_d.rst_st   = cpuex_pkg::RST_RUN;
          st_d.in_reset = 1'b0;
          st_d.rcnt     = '0;
        end else if (st_q.rcnt == '0) begin
          // Period elapsed: read the reset address again and acknowledge
          st_d.rst_ack    = 1'b1;
          st_d.rst_rd_req = 1'b1;
          st_d.rcnt       = cpuex_pkg::RCNT_RELOAD;
        end else begin
          st_d.rcnt = st_q.rcnt - 1'b1;
        end
      end
      default: begin
        st_d.rst_st   = cpuex_pkg::RST_RUN;
        st_d.in_reset = 1'b0;
      end
    endcase

    // Hardware set wins over a software clear in the same cycle
    st_d.evt = (st_q.evt & ~evt_clr) | evt_set;
  end

  // Single state register; global reset acts without waiting for the pipeline
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= cpuex_pkg::STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs taken straight from the state register
  assign reg_rdata       = st_q.rdata;
  assign exc_take        = st_q.exc.take;
  assign exc_cause       = st_q.exc.cause;
  assign exc_addr        = st_q.exc.addr;
  assign ci_vec_result   = st_q.ci_result;
  assign ci_vec_done     = st_q.ci_done;
  assign local_reset_ack = st_q.rst_ack;
  assign core_in_reset   = st_q.in_reset;
  assign rst_rd_req      = st_q.rst_rd_req;

  // Read data of the held-reset fetch are never looked at
  assign rst_rd_addr = RESET_ADDR;

  // Level interrupt while any unmasked sticky event stands
  assign irq_out = |(st_q.evt & st_q.evt_mask);

endmodule

// File: cpuex_ctrl_props.sv
// Port-level checks of the exception, interrupt and reset controller
`timescale 1ns/1ps

module cpuex_ctrl_props #(
  parameter logic [cpuex_pkg::DATA_W-1:0] EXC_ADDR = 32'h00000020  // Common exception address
) (
  input wire logic                          mclk,
  input wire logic                          rst_n,
  input wire logic [cpuex_pkg::IRQ_N-1:0]   irq_in,
  input wire logic                          issue_valid,
  input wire logic [cpuex_pkg::OP_W-1:0]    issue_op,
  input wire logic                          issue_stall,
  input wire logic                          pipe_empty,
  input wire logic                          exc_take,
  input wire logic [cpuex_pkg::CAUSE_W-1:0] exc_cause,
  input wire logic [cpuex_pkg::DATA_W-1:0]  exc_addr,
  input wire logic                          ci_vec_req,
  input wire logic [cpuex_pkg::DATA_W-1:0]  ci_vec_result,
  input wire logic                          ci_vec_done,
  input wire logic                          local_reset_req,
  input wire logic                          local_reset_ack,
  input wire logic                          core_in_reset,
  input wire logic                          dbg_active,
  input wire logic                          rst_rd_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Instruction accepted at a boundary
  sequence s_bnd;
    issue_valid && !issue_stall;
  endsequence

  // Fifteen cycles held in reset after an acknowledge
  sequence s_hold;
    local_reset_ack ##1 (local_reset_req && core_in_reset)[*8]
      ##1 (local_reset_req && core_in_reset)[*7];
  endsequence

  property p_trap;
    s_bnd ##0 (issue_op != cpuex_pkg::OP_OTHER && irq_in == '0)
      |=> exc_take && exc_cause == cpuex_pkg::CAUSE_UNIMP;
  endproperty
  property p_quiet;
    (!issue_valid || issue_stall || (issue_op == cpuex_pkg::OP_OTHER && irq_in == '0))
      |=> !exc_take;
  endproperty
  property p_addr;
    exc_take |-> exc_addr == EXC_ADDR;
  endproperty
  property p_ack;
    local_reset_ack |-> rst_rd_req && core_in_reset ##1 !local_reset_ack;
  endproperty
  property p_period;
    s_hold |=> local_reset_ack;
  endproperty
  property p_enter;
    !issue_stall && local_reset_req && !dbg_active |=> issue_stall;
  endproperty
  property p_dbg;
    !issue_stall && dbg_active |=> !issue_stall;
  endproperty
  property p_drain;
    issue_stall && !core_in_reset && !pipe_empty |=> issue_stall && !core_in_reset;
  endproperty
  property p_held;
    core_in_reset && local_reset_req |=> core_in_reset;
  endproperty
  property p_release;
    core_in_reset && !local_reset_req |=> !core_in_reset && !issue_stall;
  endproperty
  property p_vec;
    ci_vec_req && irq_in == '0 |=> ci_vec_done && ci_vec_result == cpuex_pkg::VEC_NONE;
  endproperty

  a_trap: assert property (p_trap) else $error("trap not taken");
  a_quiet: assert property (p_quiet) else $error("stray redirect");
  a_addr: assert property (p_addr) else $error("wrong redirect address");
  a_ack: assert property (p_ack) else $error("bad acknowledge pulse");
  a_period: assert property (p_period) else $error("acknowledge not repeated");
  a_enter: assert property (p_enter) else $error("local reset not started");
  a_dbg: assert property (p_dbg) else $error("reset taken under debug");
  a_drain: assert property (p_drain) else $error("reset before pipe empty");
  a_held: assert property (p_held) else $error("left reset while requested");
  a_release: assert property (p_release) else $error("reset not released");
  a_vec: assert property (p_vec) else $error("bad empty dispatch");
endmodule

bind cpuex_ctrl cpuex_ctrl_props #(.EXC_ADDR(EXC_ADDR)) cpuex_ctrl_props_i (
  .mclk, .rst_n, .irq_in, .issue_valid, .issue_op, .issue_stall, .pipe_empty, .exc_take,
  .exc_cause, .exc_addr, .ci_vec_req, .ci_vec_result, .ci_vec_done, .local_reset_req,
  .local_reset_ack, .core_in_reset, .dbg_active, .rst_rd_req
);

// File: cpuex_src_model.sv
// Interrupt sources and system reset-request logic facing the controller
`timescale 1ns/1ps

module cpuex_src_model (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic [cpuex_pkg::IRQ_N-1:0] irq_hold,
  input  wire logic                        rst_hold,
  output logic      [cpuex_pkg::IRQ_N-1:0] irq_lines,
  output logic                             reset_req
);
  // Sources hold their levels until told to drop them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_lines <= '0;
      reset_req <= 1'b0;
    end else begin
      irq_lines <= irq_hold;
      reset_req <= rst_hold;
    end
  end
endmodule

// File: cpuex_ctrl_test.sv
// Self-checking bench of the exception, interrupt and reset controller
`timescale 1ns/1ps

module cpuex_ctrl_test;
  localparam logic [31:0] EXC = 32'h00000040;  // Redirect address of this build
  logic        mclk = 1'b0;         // Core clock
  logic        rst_n = 1'b0;        // Global reset
  logic [3:0]  reg_addr = '0;       // Register port
  logic [31:0] reg_wdata = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] irq_in;              // Lines from the sources
  logic [31:0] irq_want = '0;       // Levels the sources hold
  logic        issue_valid = 1'b0;  // Issue side
  logic [2:0]  issue_op = '0;
  logic        issue_stall;
  logic        pipe_empty = 1'b0;
  logic        exc_return = 1'b0;   // Return from exception pulse
  logic        exc_take;
  logic [1:0]  exc_cause;
  logic [31:0] exc_addr;
  logic        ci_vec_req = 1'b0;   // Vector dispatch
  logic [31:0] ci_vec_result;
  logic        ci_vec_done;
  logic        local_reset_req;
  logic        rst_want = 1'b0;     // Request from system logic
  logic        local_reset_ack;
  logic        core_in_reset;
  logic        dbg_active = 1'b0;
  logic        rst_rd_req;
  logic [31:0] rst_rd_addr;
  logic        irq_out;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;             // Timeout count
  int          n;                   // Cycles waited
  // Rows: opcode, redirect expected, cause
  logic [5:0]  rows [8] = '{6'h00, 6'h0E, 6'h16, 6'h1E, 6'h26, 6'h2E, 6'h36, 6'h3E};

  cpuex_ctrl #(.EXC_ADDR(EXC)) cpuex_ctrl_i (
    .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_in,
    .issue_valid, .issue_op, .issue_stall, .pipe_empty, .exc_return, .exc_take,
    .exc_cause, .exc_addr, .ci_vec_req, .ci_vec_result, .ci_vec_done, .local_reset_req,
    .local_reset_ack, .core_in_reset, .dbg_active, .rst_rd_req, .rst_rd_addr, .irq_out
  );
  cpuex_src_model cpuex_src_model_i (
    .mclk, .rst_n, .irq_hold(irq_want), .rst_hold(rst_want), .irq_lines(irq_in),
    .reset_req(local_reset_req)
  );

  // Clock and hang guard
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One-cycle read, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // One instruction at a boundary
  task automatic iss(input logic [2:0] op);
    @(posedge mclk);
    issue_valid <= 1'b1;
    issue_op    <= op;
    @(posedge mclk);
    issue_valid <= 1'b0;
    #1;
  endtask

  // Vector dispatch request and its answer
  task automatic vec(input logic [31:0] exp);
    @(posedge mclk);
    ci_vec_req <= 1'b1;
    @(posedge mclk);
    ci_vec_req <= 1'b0;
    #1;
    chk(ci_vec_done, 1'b1);
    chk(ci_vec_result, exp);
  endtask

  // Bounded wait for the next acknowledge
  task automatic wait_ack;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (local_reset_ack !== 1'b1 && n < 40);
  endtask

  // Counts and verdict
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(cpuex_pkg::REG_STATUS, 32'h0);
    rd(cpuex_pkg::REG_CONFIG, 32'h0);
    rd(4'hF, 32'h0);
    wr(cpuex_pkg::REG_EVT_MASK, 32'h1);
    foreach (rows[i]) begin
      iss(rows[i][5:3]);
      chk(exc_take, rows[i][2]);
      if (rows[i][2]) begin
        chk(exc_cause, rows[i][1:0]);
        chk(exc_addr, EXC);
      end
      chk(irq_out, i > 0);
    end
    wr(cpuex_pkg::REG_EVT_MASK, 32'h0);
    chk(irq_out, 1'b0);
    rd(cpuex_pkg::REG_EVT, 32'h1);
    wr(cpuex_pkg::REG_EVT, 32'h1);
    rd(cpuex_pkg::REG_EVT, 32'h0);
    $display("trap table done");
    // Every mix of global enable, line and mask bit
    for (int k = 0; k < 8; k++) begin
      irq_want <= {28'h0, k[1], 3'h0};
      wr(cpuex_pkg::REG_ENABLE, {28'h0, k[2], 3'h0});
      wr(cpuex_pkg::REG_STATUS, {31'h0, k[0]});
      iss(cpuex_pkg::OP_OTHER);
      chk(exc_take, k == 7);
    end
    chk(exc_cause, cpuex_pkg::CAUSE_IRQ);
    rd(cpuex_pkg::REG_STATUS, 32'h2);
    rd(cpuex_pkg::REG_PENDING, 32'h8);
    // Return from the handler brings the saved enable back
    @(posedge mclk);
    exc_return <= 1'b1;
    @(posedge mclk);
    exc_return <= 1'b0;
    rd(cpuex_pkg::REG_STATUS, 32'h3);
    // Second interrupt on the top line, taken over a trap
    irq_want <= 32'h80000008;
    wr(cpuex_pkg::REG_ENABLE, 32'h80000000);
    wr(cpuex_pkg::REG_STATUS, 32'h1);
    iss(cpuex_pkg::OP_MUL);
    chk(exc_take, 1'b1);
    chk(exc_cause, cpuex_pkg::CAUSE_IRQ);
    $display("interrupt gating done");
    vec(32'h000000F8);
    wr(cpuex_pkg::REG_ENABLE, 32'h80000008);
    vec(32'h00000018);
    wr(cpuex_pkg::REG_STATUS, 32'h0);
    vec(cpuex_pkg::VEC_NONE);
    irq_want <= '0;
    vec(cpuex_pkg::VEC_NONE);
    $display("vector dispatch done");
    // Request that vanishes while debug holds the core
    dbg_active <= 1'b1;
    rst_want   <= 1'b1;
    repeat (3) @(posedge mclk);
    rst_want <= 1'b0;
    repeat (3) @(posedge mclk);
    dbg_active <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(issue_stall, 1'b0);
    // Request that outlasts debug control, with a slow pipeline
    dbg_active <= 1'b1;
    rst_want   <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk(issue_stall, 1'b0);
    dbg_active <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 chk(issue_stall, 1'b1);
    chk(core_in_reset, 1'b0);
    pipe_empty <= 1'b1;
    wait_ack;
    chk(core_in_reset, 1'b1);
    chk(rst_rd_req, 1'b1);
    chk(rst_rd_addr, 32'h0);
    wait_ack;
    chk(n, cpuex_pkg::RST_READ_CYC);
    rst_want <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(core_in_reset, 1'b0);
    $display("local reset done");
    // Global reset while held in local reset
    rst_want <= 1'b1;
    wait_ack;
    rst_n    <= 1'b0;
    rst_want <= 1'b0;
    #1 chk(core_in_reset, 1'b0);
    chk(local_reset_ack, 1'b0);
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(cpuex_pkg::REG_STATUS, 32'h0);
    $display("global reset done");
    test_done();
  end
endmodule
